// >>> design/swm_master.v
`timescale 1ns/100ps
`include "swm_map.vh"
// How it works
// - reset sequence holds the wire low 511 us, above the 480 us floor
// - reset low plus rise time stays under 960 us
// - wire stays released 512 us after reset before any slot
// - write-zero drives the wire low for 100 us
// - every slot lasts 117 us from its falling edge
// - at least 1 us of released wire between slots
// - write-one drives low 5 us, then releases for the slot rest
// - read slot drives low 5 us, then releases for the slave
// - read data sampled 15 us after the slot falling edge
// - sampled level is at most 1 us old when taken
module swm_master (
  input wire sys_clk,
  input wire resetn,
  input wire [`SWM_DIV_W-1:0] div_cfg,
  input wire cmd_valid,
  output reg cmd_ready,
  input wire [`SWM_OP_W-1:0] cmd_op,
  input wire cmd_bit,
  output wire rsp_valid,
  input wire rsp_ready,
  output wire rsp_bit,
  output reg presence,
  input wire wire_in,
  output reg wire_out,
  output reg wire_oe
);
  // ****************************************
  // states
  // ****************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RST_LOW = 3'h1;
  localparam [2:0] ST_RST_HIGH = 3'h2;
  localparam [2:0] ST_SLOT_LOW = 3'h3;
  localparam [2:0] ST_SLOT_HIGH = 3'h4;
  localparam [2:0] ST_REC = 3'h5;
  localparam [2:0] ST_PUSH = 3'h6;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`SWM_DIV_W-1:0] div_q;
  reg [`SWM_CNT_W-1:0] us_q;
  reg restart;
  reg [`SWM_OP_W-1:0] op_q;
  reg wbit_q;
  reg rbit_q;
  reg smp_q;
  reg sync1_q;
  reg sync2_q;
  reg sync3_q;
  reg lvl_q;
  reg [`SWM_CNT_W-1:0] low_lim;
  wire tick;
  wire buf_ready;
  wire buf_valid;
  wire buf_bit;

  // true on the tick that completes lim microseconds
  function reached;
    input [`SWM_CNT_W-1:0] us;
    input [`SWM_CNT_W-1:0] lim;
    input t;
    begin
      reached = t & (us == lim - `SWM_CNT_W'd1);
    end
  endfunction

  // ****************************************
  // wire input synchroniser
  // ****************************************
  // three stages, level accepted once stages two and three agree
  always @(posedge sys_clk) begin
    if (!resetn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
      lvl_q <= 1'b1;
    end else begin
      sync1_q <= wire_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        lvl_q <= sync3_q;
      end
    end
  end

  // ****************************************
  // microsecond tick
  // ****************************************
  assign tick = (div_q == div_cfg);

  // divider and microsecond count, both cleared at phase start
  always @(posedge sys_clk) begin
    if (!resetn) begin
      div_q <= {`SWM_DIV_W{1'b0}};
      us_q <= {`SWM_CNT_W{1'b0}};
    end else if (restart) begin
      div_q <= {`SWM_DIV_W{1'b0}};
      us_q <= {`SWM_CNT_W{1'b0}};
    end else if (tick) begin
      div_q <= {`SWM_DIV_W{1'b0}};
      us_q <= us_q + `SWM_CNT_W'd1;
    end else begin
      div_q <= div_q + `SWM_DIV_W'd1;
    end
  end

  // ****************************************
  // slot low time by command
  // ****************************************
  always @* begin
    if (op_q == `SWM_OP_READ) begin
      low_lim = `SWM_LOWR_US;
    end else if (wbit_q) begin
      low_lim = `SWM_LOW1_US;
    end else begin
      low_lim = `SWM_LOW0_US;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always @* begin
    state_d = state_q;
    restart = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (cmd_valid && cmd_ready) begin
          restart = 1'b1;
          if (cmd_op == `SWM_OP_RESET) begin
            state_d = ST_RST_LOW;
          end else begin
            state_d = ST_SLOT_LOW;
          end
        end
      end
      ST_RST_LOW: begin
        // 511 us sits between 480 and the 960 us ceiling
        if (reached(us_q, `SWM_RSTL_US, tick)) begin
          state_d = ST_RST_HIGH;
          restart = 1'b1;
        end
      end
      ST_RST_HIGH: begin
        if (reached(us_q, `SWM_RSTH_US, tick)) begin
          state_d = ST_PUSH;
        end
      end
      ST_SLOT_LOW: begin
        if (reached(us_q, low_lim, tick)) begin
          state_d = ST_SLOT_HIGH; // count keeps running from the fall
        end
      end
      ST_SLOT_HIGH: begin
        if (reached(us_q, `SWM_SLOT_US, tick)) begin
          state_d = ST_REC;
          restart = 1'b1;
        end
      end
      ST_REC: begin
        if (reached(us_q, `SWM_REC_US, tick)) begin
          state_d = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (buf_ready) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // state, wire drive and captured data
  // ****************************************
  always @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cmd_ready <= 1'b0;
      op_q <= `SWM_OP_RESET;
      wbit_q <= 1'b0;
      wire_oe <= 1'b0;
      wire_out <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_ready <= (state_d == ST_IDLE);
      wire_out <= 1'b0; // open drain: only ever pulls low
      wire_oe <= (state_d == ST_RST_LOW) || (state_d == ST_SLOT_LOW);
      if (cmd_valid && cmd_ready) begin
        op_q <= cmd_op;
        wbit_q <= cmd_bit;
      end
    end
  end

  // ****************************************
  // read sample and presence detect
  // ****************************************
  // single sample per read slot, level taken from the wire four clocks (40 ns) earlier
  always @(posedge sys_clk) begin
    if (!resetn) begin
      rbit_q <= 1'b1;
      smp_q <= 1'b0;
      presence <= 1'b0;
    end else begin
      if (restart && state_q == ST_IDLE) begin
        smp_q <= 1'b0;
      end else if (state_q == ST_SLOT_HIGH && op_q == `SWM_OP_READ &&
                   us_q == `SWM_RDV_US && !smp_q) begin
        rbit_q <= lvl_q;
        smp_q <= 1'b1;
      end
      // window covers slave wait plus longest presence pulse
      if (state_q == ST_RST_LOW) begin
        presence <= 1'b0;
      end else if (state_q == ST_RST_HIGH && !lvl_q &&
                   us_q >= `SWM_PDH_MIN_US &&
                   us_q < `SWM_PDH_MAX_US + `SWM_PDL_MAX_US) begin
        presence <= 1'b1;
      end
    end
  end

  // ****************************************
  // response buffer
  // ****************************************
  assign rsp_valid = buf_valid;
  assign rsp_bit = buf_bit;

  swm_skid #(
    .W(1)
  ) u_rsp (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(state_q == ST_PUSH),
    .in_ready(buf_ready),
    .in_data((op_q == `SWM_OP_RESET) ? presence :
             (op_q == `SWM_OP_READ) ? rbit_q : wbit_q),
    .out_valid(buf_valid),
    .out_ready(rsp_ready),
    .out_data(buf_bit)
  );
endmodule // swm_master

// >>> design/swm_map.vh
`ifndef SWM_MAP_VH
`define SWM_MAP_VH
// ****************************************
// clock and tick
// ****************************************
`define SWM_CLK_PERIOD_NS 10
`define SWM_US_NS 1000
`define SWM_TICK_CYC (`SWM_US_NS / `SWM_CLK_PERIOD_NS)
`define SWM_DIV_W 10
// ****************************************
// times in microseconds
// ****************************************
`define SWM_CNT_W 10
`define SWM_RSTL_US 10'h1FF
`define SWM_RSTL_LIMIT_US 10'h3C0
`define SWM_RSTH_US 10'h200
`define SWM_PDH_MIN_US 10'h00F
`define SWM_PDH_MAX_US 10'h03C
`define SWM_PDL_MAX_US 10'h0F0
`define SWM_LOW0_US 10'h064
`define SWM_LOW1_US 10'h005
`define SWM_LOWR_US 10'h005
`define SWM_SLOT_US 10'h075
`define SWM_RDV_US 10'h00F
`define SWM_REC_US 10'h001
// ****************************************
// command codes
// ****************************************
`define SWM_OP_W 2
`define SWM_OP_RESET 2'h0
`define SWM_OP_WRITE 2'h1
`define SWM_OP_READ 2'h2
`endif

// >>> design/swm_skid.v
`timescale 1ns/100ps
// ****************************************
// two-entry buffer, all outputs registered
// ****************************************
module swm_skid #(
  parameter W = 1
) (
  input wire sys_clk,
  input wire resetn,
  input wire in_valid,
  output reg in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [W-1:0] out_data
);
  reg [W-1:0] skid_q;
  reg skid_v_q;
  reg skid_v_d;
  wire push;
  wire pop;
  wire head_free;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign head_free = ~out_valid | pop;

  // next occupancy of the spare entry
  always @* begin
    skid_v_d = skid_v_q;
    if (head_free) begin
      skid_v_d = 1'b0;
    end else if (push) begin
      skid_v_d = 1'b1;
    end
  end

  // head and spare entry update
  always @(posedge sys_clk) begin
    if (!resetn) begin
      out_valid <= 1'b0;
      out_data <= {W{1'b0}};
      skid_q <= {W{1'b0}};
      skid_v_q <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      if (head_free) begin
        out_valid <= skid_v_q | push;
        if (skid_v_q) begin
          out_data <= skid_q;
        end else if (push) begin
          out_data <= in_data;
        end
      end
      if (!head_free && push) begin
        skid_q <= in_data;
      end
      skid_v_q <= skid_v_d;
      in_ready <= ~skid_v_d; // stall once both entries hold words
    end
  end
endmodule // swm_skid

// >>> dv/swm_master_assertions.sv
`timescale 1ns/100ps
`include "swm_map.vh"
// ****
// wire timing checks
// ****
module swm_master_chk (
  input wire sys_clk,
  input wire resetn,
  input wire [`SWM_DIV_W-1:0] div_cfg,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [`SWM_OP_W-1:0] cmd_op,
  input wire cmd_bit,
  input wire rsp_valid,
  input wire rsp_ready,
  input wire rsp_bit,
  input wire presence,
  input wire wire_in,
  input wire wire_out,
  input wire wire_oe
);
  int t;
  int lo_q;
  int hi_q;
  int last_q;
  // cycles per microsecond, then run lengths of driven and released wire
  assign t = div_cfg + 1;
  always @(posedge sys_clk) begin
    if (!resetn) begin
      lo_q <= 0;
      hi_q <= 0;
      last_q <= 0;
    end else begin
      lo_q <= wire_oe ? lo_q + 1 : 0;
      hi_q <= wire_oe ? 0 : hi_q + 1;
      if (wire_oe) last_q <= lo_q + 1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_start;
    wire_oe && !cmd_ready;
  endsequence
  a_low_legal: assert property ($fell(wire_oe) |->
    lo_q == 5*t || lo_q == 100*t || lo_q == 511*t) else $error("bad low length");
  a_reset_cap: assert property (wire_oe |-> lo_q < 511*t)
    else $error("low too long");
  a_gap_min: assert property ($rose(wire_oe) |-> last_q == 0 ||
    (last_q == 511*t ? hi_q >= 512*t : hi_q >= (last_q == 100*t ? 18*t : 113*t)))
    else $error("release gap short");
  a_take_start: assert property (s_take |=> s_start)
    else $error("slot not started");
  a_busy_low: assert property (wire_oe |-> !cmd_ready)
    else $error("ready while driving");
  a_drive_zero: assert property (!wire_out)
    else $error("wire driven high");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_bit))
    else $error("response lost");
  a_pres_set: assert property ($rose(presence) |-> !wire_oe && !cmd_ready)
    else $error("presence set outside sequence");
endmodule // swm_master_chk
bind swm_master swm_master_chk u_chk (.sys_clk(sys_clk), .resetn(resetn), .div_cfg(div_cfg),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_bit(cmd_bit),
  .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_bit(rsp_bit), .presence(presence),
  .wire_in(wire_in), .wire_out(wire_out), .wire_oe(wire_oe));

// >>> dv/swm_slave.sv
`timescale 1ns/100ps
// ****
// slave on the wire
// ****
module swm_slave #(
  parameter real US = 20.0
) (
  input wire line,
  input wire present,
  input wire rd_en,
  input wire rd_bit,
  input wire [7:0] pd_us,
  input wire [7:0] pl_us,
  output reg pull
);
  realtime t0;
  initial pull = 1'b0;
  // slot start: a zero being read holds the wire 30 us
  always @(negedge line) begin
    t0 = $realtime;
    if (!pull && rd_en && !rd_bit) begin
      pull = 1'b1;
      #(30 * US) pull = 1'b0;
    end
  end
  // end of a long low: presence pulse after a delay
  always @(posedge line) begin
    if (!pull && $realtime - t0 >= 480 * US && present) begin
      #(pd_us * US) pull = 1'b1;
      #(pl_us * US) pull = 1'b0;
    end
  end
endmodule // swm_slave

// >>> dv/swm_master_test.sv
`timescale 1ns/100ps
`include "swm_map.vh"
module swm_master_test;
  reg sys_clk = 1'b0;
  reg resetn = 1'b0;
  reg [`SWM_DIV_W-1:0] div_cfg = 10'h001;
  reg cmd_valid = 1'b0;
  reg [`SWM_OP_W-1:0] cmd_op = `SWM_OP_RESET;
  reg cmd_bit = 1'b0, rsp_ready = 1'b0, present = 1'b1, rd_en = 1'b0, rd_bit = 1'b1;
  reg [7:0] pd_us = 8'h0F, pl_us = 8'h3C;
  wire cmd_ready, rsp_valid, rsp_bit, presence, wire_out, wire_oe, pull;
  wire line = !(wire_oe || pull); // pull-up unless someone sinks
  int failures = 0, samples_checked = 0;
  bit exp_q[$];
  always #5 sys_clk = ~sys_clk;
  swm_master uut (.sys_clk(sys_clk), .resetn(resetn), .div_cfg(div_cfg), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_bit(cmd_bit), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_bit(rsp_bit), .presence(presence), .wire_in(line),
    .wire_out(wire_out), .wire_oe(wire_oe));
  swm_slave slave (.line(line), .present(present), .rd_en(rd_en), .rd_bit(rd_bit),
    .pd_us(pd_us), .pl_us(pl_us), .pull(pull));
  // ****
  // tasks
  // ****
  task report_and_stop;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s exp %b got %b", name, exp, got);
    end
  endtask
  task lim(inout int n);
    n++;
    if (n > 5000) begin
      failures++;
      report_and_stop;
    end
  endtask
  // one command, expected response queued
  task send(input logic [1:0] op, input logic b, input logic e);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      @(negedge sys_clk);
      lim(n);
    end
    cmd_op = op;
    cmd_bit = b;
    cmd_valid = 1'b1;
    exp_q.push_back(e);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask
  // one response, consumer stalls a few cycles
  task take(input string name);
    int n;
    n = 0;
    while (rsp_valid !== 1'b1) begin
      @(negedge sys_clk);
      lim(n);
    end
    repeat (1 + $urandom % 4) @(negedge sys_clk); // stall 1 to 4 cycles with rsp_ready low before checking
    chk(name, exp_q.pop_front(), rsp_bit);
    rsp_ready = 1'b1;
    @(negedge sys_clk);
    rsp_ready = 1'b0;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    void'($urandom(32'h8F44));
    repeat (6) @(negedge sys_clk);
    resetn = 1'b1;
    // presence: early short pulse, late long pulse, nobody there
    for (int i = 0; i < 3; i++) begin
      present = (i < 2);
      pd_us = i ? 8'h3C : 8'h0F;
      pl_us = i ? 8'hF0 : 8'h3C;
      send(`SWM_OP_RESET, 1'b0, i < 2);
      take("presence_rsp");
      chk("presence", i < 2, presence);
    end
    // random write and read slots
    for (int i = 0; i < 16; i++) begin
      logic b;
      b = $urandom % 2;
      rd_en = i[0];
      rd_bit = b;
      send(i[0] ? `SWM_OP_READ : `SWM_OP_WRITE, b, b);
      take("slot_rsp");
    end
    // buffer full: third response waits and the master stays busy
    rd_en = 1'b0;
    for (int i = 0; i < 3; i++) send(`SWM_OP_WRITE, i[0], i[0]);
    repeat (400) @(negedge sys_clk);
    chk("ready_when_full", 1'b0, cmd_ready);
    for (int i = 0; i < 3; i++) take("buffered_rsp");
    report_and_stop;
  end
endmodule // swm_master_test
